// ==== common/sacr_pkg.sv ====
// Package: constants, types and helpers of the serial converter command/result port
//
// Summary of operation
// - Sampling starts at fourth falling shift edge
// - Sampling ends at frame length; flag drops later
// - Bit order applies to the next frame
// - Unsigned: low ref zeros, high ref ones
// - Signed: same code with top bit inverted
// - Format applies to conversion of this command
// - Flag high at reset and during sampling
// - Flag rises on result latch, then reset
// - First bit appears at flag rise or select
// - Each falling shift edge advances output bit
// - Twelve bits, top aligned, pad or truncate
// - Output forced low while converting
// - Deselect floats output, then ignores clock
// - Debounced select high resets the port
// - Abort keeps previous result in buffer
// - Address 1110 enters power-down at edge four
// - Starts powered down until valid address arrives
// - Codes 0000 to 1010 pick external inputs
// - Sample held at last falling shift edge
// - Length code 01=8, 11=16, else 12
// - Input select applies to conversion of this command
package sacr_pkg;

  // ****************************************
  // Widths, fields and codes
  // ****************************************
  localparam int         CMD_W           = 8;
  localparam int         RES_W           = 12;
  localparam int         CNT_W           = 5;
  localparam int         TMR_W           = 9;
  localparam logic [4:0] CNT_MAX         = 5'h1f;
  localparam logic [4:0] EDGE_ADDR       = 5'h04;
  localparam logic [4:0] EDGE_LEN        = 5'h06;
  localparam logic [4:0] LEN_8           = 5'h08;
  localparam logic [4:0] LEN_12          = 5'h0c;
  localparam logic [4:0] LEN_16          = 5'h10;
  localparam logic [4:0] PAD_BITS        = 5'h04;
  localparam logic [4:0] RES_TOP         = 5'h0b;
  localparam logic [1:0] LEN_CODE_8      = 2'h1;
  localparam logic [1:0] LEN_CODE_16     = 2'h3;
  localparam logic [3:0] ADDR_POWER_DOWN = 4'he;
  localparam logic [3:0] ADDR_LAST_EXT   = 4'ha;
  localparam logic [11:0] RES_RESET      = 12'h000;
  localparam logic [11:0] SIGN_MASK      = 12'h800;

  // ****************************************
  // Timing
  // ****************************************
  localparam int SYS_CLK_MHZ   = 25;
  localparam int FLAG_DELAY_NS = 200;
  localparam int CONV_TIME_NS  = 10000;
  localparam int DEBOUNCE_NS   = 200;
  localparam int FLAG_DELAY_CYC_I = (FLAG_DELAY_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int CONV_CYC_I       = (CONV_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int DEBOUNCE_CYC_I   = (DEBOUNCE_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam logic [8:0] FLAG_DELAY_CYC = 9'(FLAG_DELAY_CYC_I < 1 ? 1 : FLAG_DELAY_CYC_I);
  localparam logic [8:0] CONV_CYC       = 9'(CONV_CYC_I < 1 ? 1 : CONV_CYC_I);
  localparam logic [8:0] DEBOUNCE_CYC   = 9'(DEBOUNCE_CYC_I < 1 ? 1 : DEBOUNCE_CYC_I);

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [3:0] input_select_field;
    logic       length_select_high;
    logic       length_select_low;
    logic       lsb_first_bit;
    logic       signed_format_bit;
  } sacr_cmd_t;

  typedef struct packed {
    logic [11:0] word;
    logic        lsb_first;
  } sacr_result_t;

  typedef enum logic [4:0] {
    ST_REARM  = 5'b00001,
    ST_IDLE   = 5'b00010,
    ST_SAMPLE = 5'b00100,
    ST_DELAY  = 5'b01000,
    ST_CONV   = 5'b10000
  } sacr_state_t;

  // Frame length from the length field
  function automatic logic [4:0] frame_len(sacr_cmd_t c);
    logic [1:0] code;
    code = {c.length_select_high, c.length_select_low};
    if (code == LEN_CODE_8) return LEN_8;
    else if (code == LEN_CODE_16) return LEN_16;
    else return LEN_12;
  endfunction

endpackage

// ==== logic/sacr_link_front.sv ====
// Shift-clock domain front end: command capture and falling-edge counter
`timescale 1ns/1ps
module sacr_link_front
  import sacr_pkg::*;
(
  input  wire logic       link_clk_i,
  input  wire logic       link_rst_i,
  input  wire logic       cmd_bit_i,
  output sacr_cmd_t       cmd_o,
  output logic [4:0]      cnt_gray_o
);

  // ****************************************
  // State on falling shift edges
  // ****************************************
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic [7:0] cmd_r;
  logic [7:0] cmd_nxt;
  logic [4:0] gray_r;
  logic [4:0] gray_nxt;

  // Next values: count edges, place command bits top first
  // Each bit lands in its final place, so a field already in stays still
  // while the system side reads it across the clock boundary
  always_comb begin
    cnt_nxt  = (cnt_r == CNT_MAX) ? cnt_r : cnt_r + 5'h01;
    cmd_nxt  = cmd_r;
    if (cnt_r < 5'(CMD_W)) begin
      cmd_nxt[3'(5'(CMD_W - 1) - cnt_r)] = cmd_bit_i;
    end
    gray_nxt = cnt_nxt ^ (cnt_nxt >> 1);
  end

  // Registers; reset held by the system domain while deselected
  always_ff @(negedge link_clk_i or posedge link_rst_i) begin
    if (link_rst_i) begin
      cnt_r  <= 5'h00;
      cmd_r  <= 8'h00;
      gray_r <= 5'h00;
    end else begin
      cnt_r  <= cnt_nxt;
      cmd_r  <= cmd_nxt;
      gray_r <= gray_nxt;
    end
  end

  assign cmd_o      = sacr_cmd_t'(cmd_r);
  assign cnt_gray_o = gray_r;

endmodule

// ==== logic/sacr_port.sv ====
// Serial converter command/result port: sequencing, result buffer, output framing
`timescale 1ns/1ps
module sacr_port
  import sacr_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        shift_clk_i,
  input  wire logic        device_select_n_i,
  input  wire logic        serial_command_in_i,
  input  wire logic [11:0] sar_data_i,
  output logic             serial_result_out_o,
  output logic             serial_result_oe_o,
  output logic             conversion_done_flag_o,
  output logic             sample_o,
  output logic             conv_start_o,
  output logic [3:0]       mux_select_o,
  output logic             power_down_o
);

  // ****************************************
  // Helpers
  // ****************************************

  // Gray to binary for the synchronised edge count
  function automatic logic [4:0] gray2bin(logic [4:0] g);
    logic [4:0] b;
    b[4] = g[4];
    for (int i = 3; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // Result bit shown after idx falling edges
  function automatic logic out_bit(logic [11:0] w, logic lsb, logic [4:0] len,
                                   logic [4:0] idx);
    logic b;
    b = 1'b0;
    if (idx < len) begin
      if (len == LEN_16) begin
        if (lsb) begin
          if (idx >= PAD_BITS) b = w[4'(idx - PAD_BITS)];
        end else if (idx <= RES_TOP) begin
          b = w[4'(RES_TOP - idx)];
        end
      end else if (lsb) begin
        b = w[4'(idx + ((len == LEN_8) ? PAD_BITS : 5'h00))];
      end else begin
        b = w[4'(RES_TOP - idx)];
      end
    end
    return b;
  endfunction

  // ****************************************
  // Link-domain front end
  // ****************************************
  sacr_cmd_t  link_cmd;
  logic [4:0] link_gray;
  logic       link_rst_r;

  sacr_link_front u_front (
    .link_clk_i (shift_clk_i),
    .link_rst_i (link_rst_r),
    .cmd_bit_i  (serial_command_in_i),
    .cmd_o      (link_cmd),
    .cnt_gray_o (link_gray)
  );

  // ****************************************
  // Synchronisers
  // ****************************************
  logic       sel_meta_r;
  logic       sel_sync_r;
  logic [4:0] gray_meta_r;
  logic [4:0] gray_sync_r;
  logic [4:0] cnt_s;

  // Two flops for select pin and edge count
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sel_meta_r  <= 1'b1;
      sel_sync_r  <= 1'b1;
      gray_meta_r <= 5'h00;
      gray_sync_r <= 5'h00;
    end else begin
      sel_meta_r  <= device_select_n_i;
      sel_sync_r  <= sel_meta_r;
      gray_meta_r <= link_gray;
      gray_sync_r <= gray_meta_r;
    end
  end

  assign cnt_s = gray2bin(gray_sync_r);

  // ****************************************
  // Select debounce
  // ****************************************
  logic       sel_db_r;
  logic       sel_db_nxt;
  logic [8:0] db_cnt_r;
  logic [8:0] db_cnt_nxt;

  // Level must differ for the full time before it is taken
  always_comb begin
    sel_db_nxt = sel_db_r;
    db_cnt_nxt = 9'h000;
    if (sel_sync_r != sel_db_r) begin
      if (db_cnt_r == DEBOUNCE_CYC - 9'h001) begin
        sel_db_nxt = sel_sync_r;
      end else begin
        db_cnt_nxt = db_cnt_r + 9'h001;
      end
    end
  end

  // Debounce registers
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sel_db_r <= 1'b1;
      db_cnt_r <= 9'h000;
    end else begin
      sel_db_r <= sel_db_nxt;
      db_cnt_r <= db_cnt_nxt;
    end
  end

  // ****************************************
  // Conversion sequencer and result buffer
  // ****************************************
  sacr_state_t  state_r;
  sacr_state_t  state_nxt;
  logic [8:0]   tmr_r;
  logic [8:0]   tmr_nxt;
  logic         flag_nxt;
  logic         pd_nxt;
  logic         sample_nxt;
  logic         start_nxt;
  logic [3:0]   mux_nxt;
  logic         conv_ok_r;
  logic         conv_ok_nxt;
  logic         conv_sgn_r;
  logic         conv_sgn_nxt;
  logic         conv_lsb_r;
  logic         conv_lsb_nxt;
  logic [4:0]   prev_len_r;
  logic [4:0]   prev_len_nxt;
  logic [4:0]   len_now;
  logic [4:0]   idx;
  sacr_result_t res_r;
  sacr_result_t res_nxt;
  logic         dout_nxt;
  logic         oe_nxt;
  logic         link_rst_nxt;

  // Length of the frame in progress; the old one until the field is in
  // While rearming the link word is cleared, so the old length holds
  assign len_now = (cnt_s >= EDGE_LEN && state_r != ST_REARM) ?
                   frame_len(link_cmd) : prev_len_r;

  // Next state of the sequencer
  always_comb begin
    state_nxt    = state_r;
    tmr_nxt      = tmr_r;
    flag_nxt     = conversion_done_flag_o;
    pd_nxt       = power_down_o;
    sample_nxt   = sample_o;
    start_nxt    = 1'b0;
    mux_nxt      = mux_select_o;
    conv_ok_nxt  = conv_ok_r;
    conv_sgn_nxt = conv_sgn_r;
    conv_lsb_nxt = conv_lsb_r;
    prev_len_nxt = prev_len_r;
    res_nxt      = res_r;
    unique case (state_r)
      ST_REARM: begin
        if (!sel_db_r && cnt_s == 5'h00) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (cnt_s >= EDGE_ADDR) begin
          state_nxt = ST_SAMPLE;
          if (link_cmd.input_select_field == ADDR_POWER_DOWN) begin
            pd_nxt      = 1'b1;
            conv_ok_nxt = 1'b0;
          end else begin
            pd_nxt      = 1'b0;
            conv_ok_nxt = 1'b1;
            sample_nxt  = 1'b1;
            mux_nxt     = link_cmd.input_select_field;
          end
        end
      end
      ST_SAMPLE: begin
        if (cnt_s >= frame_len(link_cmd)) begin
          sample_nxt   = 1'b0;
          prev_len_nxt = frame_len(link_cmd);
          conv_sgn_nxt = link_cmd.signed_format_bit;
          conv_lsb_nxt = link_cmd.lsb_first_bit;
          tmr_nxt      = FLAG_DELAY_CYC - 9'h001;
          state_nxt    = conv_ok_r ? ST_DELAY : ST_REARM;
        end
      end
      ST_DELAY: begin
        if (tmr_r == 9'h000) begin
          flag_nxt  = 1'b0;
          start_nxt = 1'b1;
          tmr_nxt   = CONV_CYC - 9'h001;
          state_nxt = ST_CONV;
        end else begin
          tmr_nxt = tmr_r - 9'h001;
        end
      end
      ST_CONV: begin
        if (tmr_r == 9'h000) begin
          res_nxt.word      = sar_data_i ^ (conv_sgn_r ? SIGN_MASK : RES_RESET);
          res_nxt.lsb_first = conv_lsb_r;
          flag_nxt          = 1'b1;
          state_nxt         = ST_REARM;
        end else begin
          tmr_nxt = tmr_r - 9'h001;
        end
      end
      default: begin
        state_nxt = ST_REARM;
      end
    endcase
    // Deselect aborts anything in flight; buffer untouched
    if (sel_db_r) begin
      state_nxt  = ST_REARM;
      flag_nxt   = 1'b1;
      sample_nxt = 1'b0;
      start_nxt  = 1'b0;
      res_nxt    = res_r;
    end
  end

  // Output framing: bit index is the edge count since the frame began
  always_comb begin
    idx          = (state_nxt == ST_REARM) ? 5'h00 : cnt_s;
    dout_nxt     = 1'b0;
    if (flag_nxt) begin
      dout_nxt = out_bit(res_nxt.word, res_nxt.lsb_first, len_now, idx);
    end
    oe_nxt       = !sel_sync_r;
    link_rst_nxt = (state_nxt == ST_REARM) || sel_db_nxt;
  end

  // Sequencer registers
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_r                <= ST_REARM;
      tmr_r                  <= 9'h000;
      conversion_done_flag_o <= 1'b1;
      power_down_o           <= 1'b1;
      sample_o               <= 1'b0;
      conv_start_o           <= 1'b0;
      mux_select_o           <= 4'h0;
      conv_ok_r              <= 1'b0;
      conv_sgn_r             <= 1'b0;
      conv_lsb_r             <= 1'b0;
      prev_len_r             <= LEN_12;
      res_r                  <= '{word: RES_RESET, lsb_first: 1'b0};
      serial_result_out_o    <= 1'b0;
      serial_result_oe_o     <= 1'b0;
      link_rst_r             <= 1'b1;
    end else begin
      state_r                <= state_nxt;
      tmr_r                  <= tmr_nxt;
      conversion_done_flag_o <= flag_nxt;
      power_down_o           <= pd_nxt;
      sample_o               <= sample_nxt;
      conv_start_o           <= start_nxt;
      mux_select_o           <= mux_nxt;
      conv_ok_r              <= conv_ok_nxt;
      conv_sgn_r             <= conv_sgn_nxt;
      conv_lsb_r             <= conv_lsb_nxt;
      prev_len_r             <= prev_len_nxt;
      res_r                  <= res_nxt;
      serial_result_out_o    <= dout_nxt;
      serial_result_oe_o     <= oe_nxt;
      link_rst_r             <= link_rst_nxt;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_addr_in;
    state_r == ST_IDLE && cnt_s >= EDGE_ADDR && !sel_db_r;
  endsequence

  sequence s_frame_end;
    state_r == ST_SAMPLE && cnt_s >= frame_len(link_cmd) && conv_ok_r && !sel_db_r;
  endsequence

  sequence s_conv_done;
    state_r == ST_CONV && tmr_r == 9'h000 && !sel_db_r;
  endsequence

  property p_sample_start;
    s_addr_in ##0 (link_cmd.input_select_field != ADDR_POWER_DOWN)
      |=> sample_o && !power_down_o && mux_select_o == $past(link_cmd.input_select_field);
  endproperty
  a_sample_start: assert property (p_sample_start)
    else $error("sampling did not start on address");

  property p_power_down;
    s_addr_in ##0 (link_cmd.input_select_field == ADDR_POWER_DOWN)
      |=> power_down_o && !sample_o;
  endproperty
  a_power_down: assert property (p_power_down)
    else $error("power-down address not taken");

  property p_flag_drop;
    s_frame_end |=> !sample_o ##0 conversion_done_flag_o [*5]
      ##1 !conversion_done_flag_o && conv_start_o;
  endproperty
  a_flag_drop: assert property (p_flag_drop)
    else $error("flag did not drop after the fixed delay");

  property p_flag_high_sampling;
    sample_o |-> conversion_done_flag_o;
  endproperty
  a_flag_high_sampling: assert property (p_flag_high_sampling)
    else $error("flag low while sampling");

  property p_latch;
    s_conv_done |=> conversion_done_flag_o
      && res_r.word == ($past(sar_data_i) ^ ($past(conv_sgn_r) ? SIGN_MASK : RES_RESET));
  endproperty
  a_latch: assert property (p_latch)
    else $error("result not latched at flag rise");

  property p_signed_top;
    s_conv_done ##0 conv_sgn_r |=> res_r.word[11] != $past(sar_data_i[11])
      && res_r.word[10:0] == $past(sar_data_i[10:0]);
  endproperty
  a_signed_top: assert property (p_signed_top)
    else $error("signed format not a top-bit inversion");

  property p_zero_converting;
    !conversion_done_flag_o |-> !serial_result_out_o;
  endproperty
  a_zero_converting: assert property (p_zero_converting)
    else $error("output not forced low during conversion");

  property p_float;
    sel_sync_r |=> !serial_result_oe_o;
  endproperty
  a_float: assert property (p_float)
    else $error("output still driven after deselect");

  property p_abort_keep;
    sel_db_r |=> $stable(res_r) && conversion_done_flag_o && link_rst_r;
  endproperty
  a_abort_keep: assert property (p_abort_keep)
    else $error("abort changed the result buffer");

  property p_conv_bounded;
    $fell(conversion_done_flag_o) |-> ##[1:300] conversion_done_flag_o;
  endproperty
  a_conv_bounded: assert property (p_conv_bounded)
    else $error("conversion never completed");

endmodule

// ==== test/sacr_host_model.sv ====
// Host model: drives shift clock and command line, samples result bits
`timescale 1ns/1ps
module sacr_host_model (
  output logic            shift_clk_o,
  output logic            cmd_bit_o,
  input  wire logic       result_i,
  input  wire logic       sample_i,
  input  wire logic [3:0] mux_i
);
  logic [15:0] got_bits;
  logic        got_sample;
  logic [3:0]  got_mux;

  // ****************************************
  // Idle state
  // ****************************************
  // Clock parked low between frames
  initial begin
    shift_clk_o = 1'b0;
    cmd_bit_o   = 1'b0;
    got_bits    = 16'h0000;
    got_sample  = 1'b0;
    got_mux     = 4'h0;
  end

  // ****************************************
  // Frame
  // ****************************************
  // Exactly len edges; slow frames stretch the low phase to sample the result
  task automatic frame(input logic [7:0] cmd, input int len, input bit slow);
    int k;
    got_bits = 16'h0000;
    for (k = 0; k < len; k++) begin
      if (slow) begin
        got_bits[15-k] = result_i;
      end
      if (k == 4) begin
        got_sample = sample_i;
        got_mux    = mux_i;
      end
      if (k < 8) begin
        cmd_bit_o = cmd[7-k]; // Last bit held afterwards
      end
      #4;
      shift_clk_o = 1'b1;
      #24;
      shift_clk_o = 1'b0;
      #(slow ? 196 : 20);
    end
  endtask

endmodule

// ==== test/sacr_port_bench.sv ====
// Testbench of the serial converter command/result port
`timescale 1ns/1ps
module sacr_port_bench;
  import sacr_pkg::*;

  logic        sys_clk_i;
  logic        sys_rst_i;
  logic        select_n;
  logic [11:0] sar_data_i;
  logic        shift_clk;
  logic        cmd_bit;
  logic        dout;
  logic        oe;
  logic        flag;
  logic        sample;
  logic        conv_start;
  logic [3:0]  mux;
  logic        power_down;
  int          n_fail;
  int          check_count;
  int          f;
  int          len;
  bit          conv;
  logic [7:0]  c;
  logic [7:0]  p_cmd;
  logic [11:0] p_raw;
  logic [7:0]  cmd_tab [11];
  logic [11:0] sar_tab [11];

  sacr_port u_dut (
    .sys_clk_i              (sys_clk_i),
    .sys_rst_i              (sys_rst_i),
    .shift_clk_i            (shift_clk),
    .device_select_n_i      (select_n),
    .serial_command_in_i    (cmd_bit),
    .sar_data_i             (sar_data_i),
    .serial_result_out_o    (dout),
    .serial_result_oe_o     (oe),
    .conversion_done_flag_o (flag),
    .sample_o               (sample),
    .conv_start_o           (conv_start),
    .mux_select_o           (mux),
    .power_down_o           (power_down)
  );

  sacr_host_model u_host (
    .shift_clk_o (shift_clk),
    .cmd_bit_o   (cmd_bit),
    .result_i    (oe ? dout : 1'b1),
    .sample_i    (sample),
    .mux_i       (mux)
  );

  // ****************************************
  // Helpers
  // ****************************************
  // System clock, 40 ns
  initial sys_clk_i = 1'b0;
  always #20 sys_clk_i = ~sys_clk_i;

  // Frame length from the length field
  function automatic int len_of(logic [7:0] cmd);
    if (cmd[3:2] == 2'h1) return 8;
    else if (cmd[3:2] == 2'h3) return 16;
    else return 12;
  endfunction

  // Expected bit stream, first bit at bit 15
  function automatic logic [15:0] exp_bits(logic [11:0] raw, logic [7:0] fc, int n);
    logic [11:0] w;
    logic [15:0] u;
    logic [15:0] r;
    int          i;
    w = fc[0] ? (raw ^ 12'h800) : raw;
    u = (n == 16) ? {w, 4'h0} : (n == 12) ? {4'h0, w} : {8'h00, w[11:4]};
    r = 16'h0000;
    for (i = 0; i < n; i++) begin
      r[15-i] = fc[1] ? u[i] : u[n-1-i];
    end
    return r;
  endfunction

  // Closing report
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One comparison
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Bounded wait for the done flag
  task automatic wait_flag(input logic lvl, input int lim);
    int n;
    n = 0;
    while (flag !== lvl && n < lim) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (flag !== lvl) begin
      n_fail++;
      $display("ERROR done flag expected %b seen %b", lvl, flag);
      end_sim();
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    n_fail      = 0;
    check_count = 0;
    sys_rst_i   = 1'b1;
    select_n    = 1'b0;
    sar_data_i  = 12'h000;
    p_cmd       = 8'h00;
    p_raw       = 12'h000;
    cmd_tab = '{8'he0, 8'h30, 8'h07, 8'ha6, 8'h54, 8'h2d, 8'h98, 8'hbe, 8'hdf, 8'h3c, 8'hec};
    sar_tab = '{12'h000, 12'ha5c, 12'h3c1, 12'h123, 12'hfff, 12'h001,
                12'h5a3, 12'h9b7, 12'h444, 12'h777, 12'h000};
    repeat (12) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    repeat (20) @(negedge sys_clk_i);
    check("flag after reset", 16'h0001, 16'(flag));
    check("power down after reset", 16'h0001, 16'(power_down));
    for (f = 0; f < 11; f++) begin
      c          = cmd_tab[f];
      len        = len_of(c);
      conv       = (c[7:4] != 4'he);
      sar_data_i = sar_tab[f];
      u_host.frame(c, len, f != 0);
      if (f != 0) begin
        check("result bits", exp_bits(p_raw, p_cmd, len), u_host.got_bits);
      end
      if (conv && f != 0) begin
        check("input select", 16'(c[7:4]), 16'(u_host.got_mux));
        check("sampling at edge four", 16'h0001, 16'(u_host.got_sample));
      end
      @(negedge sys_clk_i);
      if (conv) begin
        wait_flag(1'b0, 20);
        check("start pulse at flag fall", 16'h0001, 16'(conv_start));
        check("sampling after frame", 16'h0000, 16'(sample));
        check("drive while converting", 16'h0002, 16'({oe, dout}));
        if (f == 9) begin
          select_n = 1'b1;
          repeat (4) @(negedge sys_clk_i);
          check("enable after deselect", 16'h0000, 16'(oe));
          repeat (12) @(negedge sys_clk_i);
          check("flag after abort", 16'h0001, 16'(flag));
          select_n = 1'b0;
          repeat (20) @(negedge sys_clk_i);
        end else begin
          wait_flag(1'b1, 300);
          p_raw = sar_tab[f];
          p_cmd = c;
        end
      end else begin
        repeat (20) @(negedge sys_clk_i);
        check("flag in power down", 16'h0001, 16'(flag));
      end
      check("power down state", 16'(!conv), 16'(power_down));
      repeat (10) @(negedge sys_clk_i);
    end
    end_sim();
  end

endmodule
